// ---- common/option_pkg.sv ----
// Purpose: constants for the adapter bus control and option-select block
// Assumes: 100 MHz clk, synchronous active-high rst
// Notes: option registers sit at I/O addresses 0x100..0x105
package option_pkg;
  localparam logic [15:0] ADDR_CARD_ID_LOW   = 16'h0100;
  localparam logic [15:0] ADDR_CARD_ID_HIGH  = 16'h0101;
  localparam logic [15:0] ADDR_OPT_ENABLE    = 16'h0102;
  localparam logic [15:0] ADDR_OPT_USER_A    = 16'h0103;
  localparam logic [15:0] ADDR_OPT_USER_B    = 16'h0104;
  localparam logic [15:0] ADDR_OPT_CHECK     = 16'h0105;
  localparam logic [2:0]  IDX_OPT_ENABLE     = 3'h2;
  localparam logic [2:0]  IDX_OPT_USER_A     = 3'h3;
  localparam logic [2:0]  IDX_OPT_USER_B     = 3'h4;
  localparam logic [2:0]  IDX_OPT_CHECK      = 3'h5;
  localparam int          BIT_CARD_ENABLE    = 0;
  localparam int          BIT_CHECK_FLAG     = 7;
  localparam int          BIT_CHECK_STATUS   = 6;
  localparam int          USER_BITS          = 32;
  localparam int          OPT_PINS           = 16;
  // Arbitrary identifier; replace per card
  localparam logic [15:0] CARD_ID_DEFAULT    = 16'h5a3c;
  localparam logic [7:0]  ENABLE_RESET       = 8'h00;
  localparam logic [7:0]  USER_RESET         = 8'hff;
  localparam logic [7:0]  CHECK_RESET        = 8'hff;
  localparam logic [7:0]  DATA_IDLE          = 8'h00;
  // Status pair encodings, as (status_0_n, status_1_n)
  localparam logic [1:0]  STAT_WRITE         = 2'h1;
  localparam logic [1:0]  STAT_READ          = 2'h2;
endpackage : option_pkg

// ---- src/adapter_bus_control.sv ----
// Purpose: adapter bus control strobes and option-select registers
// Assumes: all bus pins asynchronous to clk; 100 MHz clk; sync active-high rst
// Notes: strobes lag the bus by synchroniser latency (about 3 clk)
`timescale 1ns/10ps
module adapter_bus_control
  import option_pkg::*;
#(
  parameter logic [15:0] CARD_ID = CARD_ID_DEFAULT,
  // Per pin: which user bit drives it (0..31, bit 0 is the enable bit slot)
  parameter logic [OPT_PINS*5-1:0] PIN_MAP = {
    5'd18, 5'd17, 5'd16, 5'd15, 5'd14, 5'd13, 5'd12, 5'd11,
    5'd10, 5'd9,  5'd8,  5'd7,  5'd6,  5'd5,  5'd4,  5'd3},
  parameter logic [OPT_PINS-1:0] PIN_USED = 16'hffff
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // Bus cycle inputs
  input  wire logic                address_latch_n,
  input  wire logic                command_strobe_n,
  input  wire logic                status_0_n,
  input  wire logic                status_1_n,
  input  wire logic                mem_not_io,
  input  wire logic                setup_select_n,
  input  wire logic                channel_reset,
  input  wire logic [23:0]         bus_address,
  // Option data pins
  input  wire logic [7:0]          cfg_data_in,
  output logic      [7:0]          cfg_data_out,
  output logic                     cfg_data_oe,
  // Card control outputs
  output logic                     mem_read_n,
  output logic                     mem_write_n,
  output logic                     io_read_n,
  output logic                     io_write_n,
  output logic                     cfg_read_strobe_n,
  output logic                     cfg_write_strobe_n,
  output logic                     xcvr_enable_n,
  output logic                     xcvr_direction,
  // Card enable and channel check
  output logic                     card_enabled_oe,
  input  wire logic                raise_check_n,
  output logic                     channel_check_oe,
  // Option I/O pins, open drain
  input  wire logic [OPT_PINS-1:0] opt_pin_in,
  output logic      [OPT_PINS-1:0] opt_pin_oe
);
  // Synchronised pins
  logic        adl_s, cmd_s, sel_s, chk_s, crst_s;
  logic        s0_s, s1_s, mio_s;
  logic [23:0] addr_s;
  logic [7:0]  din_s;
  logic [OPT_PINS-1:0] pin_s;

  sync2 #(.WIDTH(5), .RESET_VAL(5'h1e)) u_sync_ctl (
    .clk  (clk),
    .rst  (rst),
    .din  ({address_latch_n, command_strobe_n, setup_select_n, raise_check_n,
            channel_reset}),
    .dout ({adl_s, cmd_s, sel_s, chk_s, crst_s})
  );
  sync2 #(.WIDTH(3 + 24 + 8 + OPT_PINS), .RESET_VAL('0)) u_sync_dat (
    .clk  (clk),
    .rst  (rst),
    .din  ({status_0_n, status_1_n, mem_not_io, bus_address, cfg_data_in, opt_pin_in}),
    .dout ({s0_s, s1_s, mio_s, addr_s, din_s, pin_s})
  );

  // Edge detection on synchronised strobes
  logic adl_d_reg, cmd_d_reg;
  wire  adl_fall = adl_d_reg & ~adl_s;
  wire  adl_rise = ~adl_d_reg & adl_s;
  wire  cmd_rise = ~cmd_d_reg & cmd_s;
  wire  hard_rst = rst | crst_s;

  always_ff @(posedge clk) begin
    if (rst) begin
      adl_d_reg <= 1'b1;
      cmd_d_reg <= 1'b1;
    end else begin
      adl_d_reg <= adl_s;
      cmd_d_reg <= cmd_s;
    end
  end

  // Cycle capture
  logic [1:0] stat_reg;
  logic       mio_reg, sel_lat_reg, setup_reg;
  logic [2:0] idx_reg;
  logic [15:0] addr_hi_reg;

  always_ff @(posedge clk) begin
    if (hard_rst) begin
      stat_reg    <= 2'h0;
      mio_reg     <= 1'b0;
      sel_lat_reg <= 1'b0;
      idx_reg     <= 3'h0;
      addr_hi_reg <= 16'h0000;
    end else if (adl_fall) begin
      stat_reg    <= {s0_s, s1_s};
      mio_reg     <= mio_s;
      sel_lat_reg <= ~sel_s;
      idx_reg     <= addr_s[2:0];
      addr_hi_reg <= {addr_s[15:3], 3'h0};
    end
  end

  // Setup qualification at address latch rise
  always_ff @(posedge clk) begin
    if (hard_rst) begin
      setup_reg <= 1'b0;
    end else if (adl_fall) begin
      setup_reg <= 1'b0;
    end else if (adl_rise) begin
      setup_reg <= ~sel_s;
    end
  end

  // Decode
  wire is_write   = (stat_reg == STAT_WRITE);
  wire is_read    = (stat_reg == STAT_READ);
  wire is_io      = ~mio_reg;
  wire setup_cyc  = setup_reg & sel_lat_reg & is_io & (is_read | is_write);
  wire cmd_act    = ~cmd_s;
  logic [7:0] en_reg, user_a_reg, user_b_reg, check_reg;
  wire card_on    = en_reg[BIT_CARD_ENABLE];
  wire normal_ok  = card_on & ~setup_cyc & (is_read | is_write);
  wire mem_rd_nx  = ~(normal_ok & cmd_act & ~is_io & is_read);
  wire mem_wr_nx  = ~(normal_ok & cmd_act & ~is_io & is_write);
  wire io_rd_nx   = ~(normal_ok & cmd_act & is_io & is_read);
  wire io_wr_nx   = ~(normal_ok & cmd_act & is_io & is_write);
  wire cfg_rd_nx  = ~(setup_cyc & cmd_act & is_read);
  wire cfg_wr_nx  = ~(setup_cyc & cmd_act & is_write);
  wire den_nx     = ~((normal_ok | setup_cyc) & cmd_act);
  wire dir_nx     = ~is_write;
  wire drive_nx   = setup_cyc & is_read & cmd_act;
  wire in_block   = (addr_hi_reg == ADDR_CARD_ID_LOW);
  wire cfg_wr_now = setup_cyc & is_write & cmd_rise & in_block;

  // Register file image and pin readback
  logic [USER_BITS-1:0] user_bits;
  logic [USER_BITS-1:0] read_bits;
  logic [USER_BITS-1:0] sense_one;
  logic [USER_BITS-1:0] sense_val;
  assign user_bits = {check_reg, user_b_reg, user_a_reg, en_reg};

  genvar gp, gb;
  generate
    for (gp = 0; gp < OPT_PINS; gp++) begin : g_pin
      wire [4:0] sel = PIN_MAP[gp*5 +: 5];
      wire       lvl = PIN_USED[gp] ? user_bits[sel] : 1'b1;
      always_ff @(posedge clk) begin
        if (rst) begin
          opt_pin_oe[gp] <= 1'b0;
        end else begin
          opt_pin_oe[gp] <= ~lvl;
        end
      end
    end
    for (gb = 0; gb < USER_BITS; gb++) begin : g_bit
      logic hit;
      logic val;
      always_comb begin
        hit = 1'b0;
        val = 1'b1;
        for (int p = 0; p < OPT_PINS; p++) begin
          if (PIN_USED[p] && (PIN_MAP[p*5 +: 5] == 5'(gb))) begin
            hit = 1'b1;
            val = val & pin_s[p];
          end
        end
      end
      assign sense_one[gb] = hit;
      assign sense_val[gb] = val;
      // Stored one returns pin level, stored zero or unmapped returns storage
      assign read_bits[gb] = (sense_one[gb] && user_bits[gb]) ? sense_val[gb] : user_bits[gb];
    end
  endgenerate

  // Check status bit may be forced low by a pin mapped onto it
  wire [7:0] check_view = {read_bits[24+BIT_CHECK_FLAG], read_bits[24+BIT_CHECK_STATUS],
                           read_bits[29:24]};
  wire [7:0] rd_mux =
    (idx_reg == 3'h0)           ? CARD_ID[7:0] :
    (idx_reg == 3'h1)           ? CARD_ID[15:8] :
    (idx_reg == IDX_OPT_ENABLE) ? read_bits[7:0] :
    (idx_reg == IDX_OPT_USER_A) ? read_bits[15:8] :
    (idx_reg == IDX_OPT_USER_B) ? read_bits[23:16] :
    (idx_reg == IDX_OPT_CHECK)  ? check_view : DATA_IDLE;

  // Option registers; reset channel writes, no write path for identifier
  always_ff @(posedge clk) begin
    if (hard_rst) begin
      en_reg     <= ENABLE_RESET;
      user_a_reg <= USER_RESET;
      user_b_reg <= USER_RESET;
    end else if (cfg_wr_now) begin
      unique case (idx_reg)
        IDX_OPT_ENABLE: en_reg     <= din_s;
        IDX_OPT_USER_A: user_a_reg <= din_s;
        IDX_OPT_USER_B: user_b_reg <= din_s;
        default: ;
      endcase
    end
  end

  // Check flag: a raise pulse outranks a concurrent write of one
  wire chk_wr = cfg_wr_now & (idx_reg == IDX_OPT_CHECK);
  always_ff @(posedge clk) begin
    if (hard_rst) begin
      check_reg <= CHECK_RESET;
    end else begin
      if (chk_wr) begin
        check_reg <= din_s;
      end
      if (~chk_s) begin
        check_reg[BIT_CHECK_FLAG] <= 1'b0;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge clk) begin
    if (hard_rst) begin
      mem_read_n         <= 1'b1;
      mem_write_n        <= 1'b1;
      io_read_n          <= 1'b1;
      io_write_n         <= 1'b1;
      cfg_read_strobe_n  <= 1'b1;
      cfg_write_strobe_n <= 1'b1;
      xcvr_enable_n      <= 1'b1;
      xcvr_direction     <= 1'b1;
      cfg_data_oe        <= 1'b0;
      cfg_data_out       <= DATA_IDLE;
    end else begin
      mem_read_n         <= mem_rd_nx;
      mem_write_n        <= mem_wr_nx;
      io_read_n          <= io_rd_nx;
      io_write_n         <= io_wr_nx;
      cfg_read_strobe_n  <= cfg_rd_nx;
      cfg_write_strobe_n <= cfg_wr_nx;
      xcvr_enable_n      <= den_nx;
      xcvr_direction     <= dir_nx;
      cfg_data_oe        <= drive_nx;
      cfg_data_out       <= drive_nx ? rd_mux : DATA_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      card_enabled_oe  <= 1'b0;
      channel_check_oe <= 1'b0;
    end else begin
      card_enabled_oe  <= en_reg[BIT_CARD_ENABLE] & ~crst_s;
      channel_check_oe <= ~check_reg[BIT_CHECK_FLAG] & ~crst_s;
    end
  end

  // Assertions
  a_strobe_needs_cmd: assert property (@(posedge clk) disable iff (rst)
    (!io_read_n || !io_write_n || !mem_read_n || !mem_write_n) |-> $past(cmd_act))
    else $error("card strobe without command");
  a_disabled_quiet: assert property (@(posedge clk) disable iff (rst)
    $past(!card_on) |-> (io_read_n && io_write_n && mem_read_n && mem_write_n))
    else $error("strobe while card disabled");
  a_reset_idle: assert property (@(posedge clk) disable iff (rst)
    $past(crst_s) |-> (xcvr_enable_n && !cfg_data_oe && cfg_read_strobe_n))
    else $error("outputs active under channel reset");
  a_oe_setup_read: assert property (@(posedge clk) disable iff (rst)
    cfg_data_oe |-> !cfg_read_strobe_n)
    else $error("data driven outside setup read");
  a_dir_write_low: assert property (@(posedge clk) disable iff (rst)
    $past(is_write && !crst_s) |-> !xcvr_direction)
    else $error("direction high on write");
  a_den_setup: assert property (@(posedge clk) disable iff (rst)
    (!cfg_read_strobe_n || !cfg_write_strobe_n) |-> !xcvr_enable_n)
    else $error("transceiver off in setup");
  a_enable_follow: assert property (@(posedge clk) disable iff (rst)
    ##1 (card_enabled_oe == ($past(en_reg[BIT_CARD_ENABLE]) && !$past(crst_s))))
    else $error("card enabled pin mismatch");
  a_check_raise: assert property (@(posedge clk) disable iff (rst)
    (!chk_s && !crst_s) |=> ##1 channel_check_oe)
    else $error("check not raised");
  a_write_store: assert property (@(posedge clk) disable iff (hard_rst)
    (cfg_wr_now && idx_reg == IDX_OPT_USER_A) |=> (user_a_reg == $past(din_s)))
    else $error("setup write lost");
  // Only one card or setup strobe may be active in any cycle
  a_strobe_exclusive: assert property (@(posedge clk) disable iff (rst)
    $onehot0(~{mem_read_n, mem_write_n, io_read_n, io_write_n, cfg_read_strobe_n,
               cfg_write_strobe_n}))
    else $error("two strobes at once");
  a_den_needs_cmd: assert property (@(posedge clk) disable iff (rst)
    !xcvr_enable_n |-> $past(cmd_act))
    else $error("transceiver enabled without command");
  a_oe_needs_setup: assert property (@(posedge clk) disable iff (rst)
    cfg_data_oe |-> $past(setup_cyc && is_read))
    else $error("data driven without setup read");
  // Direction may move only after a latch fall or a reset
  a_dir_held: assert property (@(posedge clk) disable iff (rst)
    $changed(xcvr_direction) |-> ($past(adl_fall, 2) || $past(hard_rst) || $past(hard_rst, 2)))
    else $error("direction moved inside a cycle");
  // Storage moves only by reset, a qualified setup write or, for the check flag, a raise pulse; option pins never touch it
  a_enable_guard: assert property (@(posedge clk) disable iff (rst)
    $changed(en_reg) |-> $past(hard_rst || (cfg_wr_now && idx_reg == IDX_OPT_ENABLE)))
    else $error("enable bit moved outside setup write");
  a_user_guard: assert property (@(posedge clk) disable iff (rst)
    ($changed(user_a_reg) || $changed(user_b_reg)) |-> $past(hard_rst || cfg_wr_now))
    else $error("user bits moved without write");
  a_flag_set: assert property (@(posedge clk) disable iff (rst)
    $rose(check_reg[BIT_CHECK_FLAG]) |-> $past(hard_rst || chk_wr))
    else $error("check flag set without cause");

  c_setup_read: cover property (@(posedge clk) !cfg_read_strobe_n ##1 cfg_read_strobe_n);
  c_setup_write: cover property (@(posedge clk) cfg_wr_now);
  c_io_read: cover property (@(posedge clk) !io_read_n);
  c_mem_write: cover property (@(posedge clk) !mem_write_n);
  c_check_raise: cover property (@(posedge clk) $fell(check_reg[BIT_CHECK_FLAG]));
endmodule : adapter_bus_control

// ---- src/sync2.sv ----
// Purpose: two-flop synchroniser for a vector of asynchronous pins
// Assumes: single clock clk, synchronous reset rst
// Notes: first stage is read only by the second stage
`timescale 1ns/10ps
module sync2 #(
  parameter int          WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Data
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= RESET_VAL;
      dout     <= RESET_VAL;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule : sync2

// ---- tb/adapter_bus_control_tb_top.sv ----
// Purpose: self-checking bench for the adapter bus control block
// Assumes: 100 MHz clk; option pins pulled up outside
// Notes: ext_low stands for an outside source pulling an option pin low
`timescale 1ns/10ps
module adapter_bus_control_tb_top;
  import option_pkg::*;
  logic        clk, rst, channel_reset, raise_check_n;
  logic        address_latch_n, command_strobe_n, status_0_n, status_1_n;
  logic        mem_not_io, setup_select_n;
  logic [23:0] bus_address;
  logic [7:0]  cfg_data_in, cfg_data_out;
  logic        cfg_data_oe, mem_read_n, mem_write_n, io_read_n, io_write_n;
  logic        cfg_read_strobe_n, cfg_write_strobe_n, xcvr_enable_n, xcvr_direction;
  logic        card_enabled_oe, channel_check_oe;
  logic [15:0] opt_pin_in, opt_pin_oe, ext_low;
  logic [8:0]  obs;
  logic [7:0]  shadow [0:7];
  logic [11:0] ops [6] = '{12'hcfa, 12'hb78, 12'h5ba, 12'h3d8, 12'h1fc, 12'hffc};
  int          err_total, comparisons;
  logic [8:0]  snap;
  logic [7:0]  rdat;

  assign obs = {mem_read_n, mem_write_n, io_read_n, io_write_n, cfg_read_strobe_n,
                cfg_write_strobe_n, xcvr_enable_n, xcvr_direction, cfg_data_oe};
  assign opt_pin_in = ~(opt_pin_oe | ext_low);

  always #5 clk = ~clk;

  adapter_bus_control adapter_bus_control_i (.clk(clk), .rst(rst),
    .address_latch_n(address_latch_n), .command_strobe_n(command_strobe_n),
    .status_0_n(status_0_n), .status_1_n(status_1_n), .mem_not_io(mem_not_io),
    .setup_select_n(setup_select_n), .channel_reset(channel_reset),
    .bus_address(bus_address), .cfg_data_in(cfg_data_in), .cfg_data_out(cfg_data_out),
    .cfg_data_oe(cfg_data_oe), .mem_read_n(mem_read_n), .mem_write_n(mem_write_n),
    .io_read_n(io_read_n), .io_write_n(io_write_n), .cfg_read_strobe_n(cfg_read_strobe_n),
    .cfg_write_strobe_n(cfg_write_strobe_n), .xcvr_enable_n(xcvr_enable_n),
    .xcvr_direction(xcvr_direction), .card_enabled_oe(card_enabled_oe),
    .raise_check_n(raise_check_n), .channel_check_oe(channel_check_oe),
    .opt_pin_in(opt_pin_in), .opt_pin_oe(opt_pin_oe));

  bus_host_model bus_host_model_i (.clk(clk), .address_latch_n(address_latch_n),
    .command_strobe_n(command_strobe_n), .status_0_n(status_0_n),
    .status_1_n(status_1_n), .mem_not_io(mem_not_io), .setup_select_n(setup_select_n),
    .bus_address(bus_address), .cfg_data_in(cfg_data_in), .obs(obs),
    .cfg_data_out(cfg_data_out), .cfg_data_oe(cfg_data_oe));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  // Pin k follows user bit k+3; a stored zero pulls the pin
  function automatic logic [15:0] pins_exp();
    logic [15:0] p;
    for (int k = 0; k < 16; k++) p[k] = ~shadow[2 + (k + 3) / 8][(k + 3) % 8];
    return p;
  endfunction : pins_exp

  task automatic sread(input logic [2:0] idx, input logic [7:0] exp);
    logic [8:0] s;
    logic [7:0] d;
    bus_host_model_i.cycle(1'b0, STAT_READ, 1'b1, {8'h00, ADDR_CARD_ID_LOW[15:3], idx},
                           8'h00, s, d);
    check("setup read strobes", s, 9'h1eb);
    check("setup read data", d, exp);
  endtask : sread

  task automatic swrite(input logic [2:0] idx, input logic [7:0] wd);
    logic [8:0] s;
    logic [7:0] d;
    bus_host_model_i.cycle(1'b0, STAT_WRITE, 1'b1, {8'h00, ADDR_CARD_ID_LOW[15:3], idx},
                           wd, s, d);
    check("setup write strobes", s, 9'h1f0);
    if (idx > 3'h1) shadow[idx] = wd;
    repeat (4) @(posedge clk);
  endtask : swrite

  // Cycles aimed at the enable register must never touch it
  task automatic run_ops(input logic en);
    logic [8:0] s, e, m;
    logic [7:0] d;
    for (int i = 0; i < 6; i++) begin
      e = en ? ops[i][8:0] : 9'h1fc;
      m = (ops[i][10:9] == 2'h0 || ops[i][10:9] == 2'h3 || !en) ? 9'h1fd : 9'h1ff;
      bus_host_model_i.cycle(ops[i][11], ops[i][10:9], 1'b0, 24'h000102, 8'h00, s, d);
      check("ordinary cycle", s & m, e & m);
    end
  endtask : run_ops

  task automatic read_all();
    sread(3'h0, CARD_ID_DEFAULT[7:0]);
    sread(3'h1, CARD_ID_DEFAULT[15:8]);
    for (int i = 2; i < 6; i++) sread(i[2:0], shadow[i]);
  endtask : read_all

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    channel_reset = 1'b0;
    raise_check_n = 1'b1;
    ext_low = 16'h0000;
    err_total = 0;
    comparisons = 0;
    shadow = '{8'h00, 8'h00, ENABLE_RESET, USER_RESET, USER_RESET, CHECK_RESET, 8'h00, 8'h00};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    check("idle outputs", obs, 9'h1fe);
    check("check idle", {card_enabled_oe, channel_check_oe}, 2'h0);
    read_all();
    $display("test reset values done");
    run_ops(1'b0);
    swrite(3'h0, 8'h00);
    swrite(3'h2, 8'h01);
    check("card enabled", card_enabled_oe, 1'b1);
    run_ops(1'b1);
    check("enable kept", card_enabled_oe, 1'b1);
    bus_host_model_i.cycle(1'b1, STAT_READ, 1'b1, 24'h000102, 8'h00, snap, rdat);
    check("select on memory cycle", snap, 9'h0fa);
    check("no data on memory cycle", rdat, DATA_IDLE);
    read_all();
    $display("test enable and cycles done");
    swrite(3'h3, 8'ha5);
    check("option pins", opt_pin_oe, pins_exp());
    ext_low <= 16'h0020;
    sread(3'h3, 8'ha4);
    ext_low <= 16'h0000;
    sread(3'h3, 8'ha5);
    $display("test option pins done");
    swrite(3'h5, 8'h7f);
    check("check raised by write", channel_check_oe, 1'b1);
    swrite(3'h5, 8'hff);
    check("check cleared by write", channel_check_oe, 1'b0);
    raise_check_n <= 1'b0;
    repeat (5) @(posedge clk);
    raise_check_n <= 1'b1;
    repeat (5) @(posedge clk);
    check("check raised by pin", channel_check_oe, 1'b1);
    sread(3'h5, 8'h7f);
    $display("test channel check done");
    fork
      read_all();
      begin
        repeat (27) @(posedge clk);
        channel_reset <= 1'b1;
      end
    join_any
    disable fork;
    bus_host_model_i.release_bus();
    repeat (4) @(posedge clk);
    check("abort outputs", obs, 9'h1fe);
    channel_reset <= 1'b0;
    shadow = '{8'h00, 8'h00, ENABLE_RESET, USER_RESET, USER_RESET, CHECK_RESET, 8'h00, 8'h00};
    repeat (40) @(posedge clk);
    check("after channel reset", {card_enabled_oe, channel_check_oe}, 2'h0);
    check("pins after reset", opt_pin_oe, pins_exp());
    sread(3'h2, 8'h00);
    $display("test channel reset done");
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    print_verdict();
  end
endmodule : adapter_bus_control_tb_top

// ---- tb/bus_host_model.sv ----
// Purpose: bus master model that runs one framed bus cycle per call
// Assumes: 100 MHz clk; each phase of a cycle at least 4 clk
// Notes: undriven data lines toggle so a stale value never reads as good
`timescale 1ns/10ps
module bus_host_model (
  // Clock
  input  wire logic        clk,
  // Bus cycle pins
  output logic             address_latch_n,
  output logic             command_strobe_n,
  output logic             status_0_n,
  output logic             status_1_n,
  output logic             mem_not_io,
  output logic             setup_select_n,
  output logic [23:0]      bus_address,
  output logic [7:0]       cfg_data_in,
  // Device side seen
  input  wire logic [8:0]  obs,
  input  wire logic [7:0]  cfg_data_out,
  input  wire logic        cfg_data_oe
);
  logic [7:0] wdata;
  logic       drv;
  logic [7:0] idle_pat = 8'h55;

  assign cfg_data_in = cfg_data_oe ? cfg_data_out : (drv ? wdata : idle_pat);

  always @(posedge clk) begin
    idle_pat <= ~idle_pat;
  end

  initial begin
    {address_latch_n, command_strobe_n, setup_select_n} = 3'h7;
    {status_0_n, status_1_n} = 2'h3;
    mem_not_io = 1'b0;
    bus_address = 24'h000000;
    wdata = 8'h00;
    drv = 1'b0;
  end

  task automatic cycle(input logic mem, input logic [1:0] stat, input logic setup,
                       input logic [23:0] addr, input logic [7:0] wd,
                       output logic [8:0] snap, output logic [7:0] rd);
    @(posedge clk);
    {status_0_n, status_1_n} <= stat;
    mem_not_io <= mem;
    setup_select_n <= ~setup;
    bus_address <= addr;
    wdata <= wd;
    drv <= (stat == 2'h1);
    repeat (4) @(posedge clk);
    address_latch_n <= 1'b0;
    repeat (10) @(posedge clk);
    address_latch_n <= 1'b1;
    repeat (10) @(posedge clk);
    command_strobe_n <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    snap = obs;
    rd = cfg_data_out;
    @(posedge clk);
    command_strobe_n <= 1'b1;
    repeat (10) @(posedge clk);
    {status_0_n, status_1_n} <= 2'h3;
    setup_select_n <= 1'b1;
    drv <= 1'b0;
  endtask : cycle

  // Returns the strobe, status, select and data pins to idle after a cycle was cut short from outside
  task automatic release_bus();
    address_latch_n          <= 1'b1;
    command_strobe_n         <= 1'b1;
    {status_0_n, status_1_n} <= 2'h3;
    setup_select_n           <= 1'b1;
    drv                      <= 1'b0;
  endtask : release_bus
endmodule : bus_host_model
